/* File: sasr_readout.sv */
// device-side serial conversion and readout logic
`timescale 1ns/1ps
module sasr_readout (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_cs_n,
    input  wire logic                      i_sclk,
    input  wire logic [sasr_pkg::DATA_W-1:0] i_ain_code,
    output logic                           o_dout,
    output logic                           o_dout_oe,
    output logic                           o_converting,
    output logic [sasr_pkg::DATA_W-1:0]   o_sample
);
    import sasr_pkg::*;

    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic       cs_d_r;
    logic       sck_d_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cs_sync_r  <= 2'h3;
            sck_sync_r <= 2'h0;
            cs_d_r     <= 1'b1;
            sck_d_r    <= 1'b0;
        end else begin
            cs_sync_r  <= {cs_sync_r[0], i_cs_n};
            sck_sync_r <= {sck_sync_r[0], i_sclk};
            cs_d_r     <= cs_sync_r[1];
            sck_d_r    <= sck_sync_r[1];
        end
    end

    //------------------------------------------------------------
    // edge detection on synchronised pins
    //------------------------------------------------------------
    function automatic logic fell_edge(input logic prev_v, input logic cur_v);
        return prev_v & ~cur_v;
    endfunction

    function automatic logic rose_edge(input logic prev_v, input logic cur_v);
        return ~prev_v & cur_v;
    endfunction

    logic cs_fall;
    logic cs_rise;
    logic sck_fall;
    assign cs_fall  = fell_edge(cs_d_r, cs_sync_r[1]);
    assign cs_rise  = rose_edge(cs_d_r, cs_sync_r[1]);
    assign sck_fall = fell_edge(sck_d_r, sck_sync_r[1]);

    //------------------------------------------------------------
    // falling edge counter and state
    //------------------------------------------------------------
    logic [CNT_W-1:0] edge_cnt_r;
    logic [CNT_W-1:0] edge_cnt_nxt;
    sasr_state_e      state_r;
    logic             conv_r;
    logic             cs_low;
    assign cs_low = ~cs_sync_r[1];

    always_comb begin
        edge_cnt_nxt = edge_cnt_r;
        if (cs_fall) begin
            // clock low at select fall: select fall is edge one; else wait
            edge_cnt_nxt = sck_sync_r[1] ? '0 : CNT_W'(1);
        end else if (cs_low && sck_fall && edge_cnt_r < EDGE_LAST) begin
            edge_cnt_nxt = edge_cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            edge_cnt_r <= '0;
        end else begin
            edge_cnt_r <= edge_cnt_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_r <= SASR_ACQ;
            conv_r  <= 1'b0;
        end else if (cs_fall) begin
            state_r <= SASR_CONV;
            conv_r  <= 1'b1;
        end else if (!cs_low) begin
            state_r <= SASR_ACQ;
            conv_r  <= 1'b0;
        end else if (edge_cnt_nxt == EDGE_LAST && sck_fall) begin
            state_r <= SASR_ACQ;
            conv_r  <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // sample capture and shift out
    //------------------------------------------------------------
    logic [DATA_W-1:0] sample_r;
    logic [DATA_W-1:0] shift_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sample_r <= '0;
        end else if (cs_fall) begin
            sample_r <= i_ain_code;
        end
    end

    logic dout_r;
    logic oe_r;
    logic step;
    assign step = cs_low && (sck_fall || cs_fall) && edge_cnt_nxt != edge_cnt_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            shift_r <= '0;
            dout_r  <= 1'b0;
            oe_r    <= 1'b0;
        end else if (!cs_low) begin
            oe_r   <= 1'b0;
            dout_r <= 1'b0;
        end else if (step) begin
            if (edge_cnt_nxt == EDGE_ZERO) begin
                oe_r    <= 1'b1;
                dout_r  <= 1'b0;
                shift_r <= sample_r;
            end else if (edge_cnt_nxt >= EDGE_MSB) begin
                dout_r  <= shift_r[DATA_W-1];
                shift_r <= {shift_r[DATA_W-2:0], 1'b0};
            end
        end
    end

    assign o_dout       = dout_r;
    assign o_dout_oe    = oe_r;
    assign o_converting = conv_r;
    assign o_sample     = sample_r;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_rise_seen;
        cs_rise;
    endsequence

    AST_OE_OFF_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !cs_low |=> !oe_r) else $error("output driven while select high");
    AST_ABORT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_rise_seen |=> state_r == SASR_ACQ && !oe_r) else $error("abort failed");
    AST_START: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_fall |=> state_r == SASR_CONV && sample_r == $past(i_ain_code))
        else $error("frame start not taken");
    AST_CNT_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_fall |=> edge_cnt_r <= CNT_W'(1)) else $error("counter not cleared");
    AST_ACQ_AT_18: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_low && sck_fall && edge_cnt_r == EDGE_LAST - CNT_W'(1) && !cs_fall
        |=> state_r == SASR_ACQ) else $error("no acquisition at edge 18");
    AST_EDGE7: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_fall && !sck_sync_r[1] |=> edge_cnt_r == CNT_W'(1)) else $error("edge one missed");
    AST_EDGE6: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_fall && sck_sync_r[1] |=> edge_cnt_r == '0) else $error("early count");
    AST_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_low && step && edge_cnt_nxt == EDGE_ZERO |=> oe_r && !dout_r)
        else $error("leading zero missing");
    AST_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !cs_low ##1 !cs_low |-> state_r == SASR_ACQ) else $error("not idle");

    //------------------------------------------------------------
    // helper tracking for the checks
    //------------------------------------------------------------
    // result bits put on the line in the current frame
    logic [CNT_W-1:0] bits_sent_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bits_sent_r <= '0;
        end else if (cs_fall) begin
            bits_sent_r <= '0;
        end else if (cs_low && step && edge_cnt_nxt >= EDGE_MSB) begin
            bits_sent_r <= bits_sent_r + CNT_W'(1);
        end
    end

    sequence s_frame_open;
        cs_fall;
    endsequence

    sequence s_clock_count;
        cs_low && sck_fall && !cs_fall && edge_cnt_r < EDGE_LAST;
    endsequence

    sequence s_clock_late;
        cs_low && sck_fall && !cs_fall && edge_cnt_r == EDGE_LAST;
    endsequence

    sequence s_last_edge;
        cs_low && sck_fall && !cs_fall && edge_cnt_r == EDGE_LAST - CNT_W'(1);
    endsequence

    sequence s_result_bit;
        cs_low && step && !cs_fall && edge_cnt_nxt >= EDGE_MSB;
    endsequence

    //------------------------------------------------------------
    // frame sequencing checks
    //------------------------------------------------------------
    AST_CNT_STEP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_clock_count |=> edge_cnt_r == $past(edge_cnt_r) + CNT_W'(1))
        else $error("clock fall not counted");

    AST_CNT_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_clock_late |=> edge_cnt_r == EDGE_LAST)
        else $error("late clock fall counted");

    AST_CNT_MAX: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        edge_cnt_r <= EDGE_LAST)
        else $error("edge count past limit");

    AST_CNT_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !cs_low |=> edge_cnt_r == $past(edge_cnt_r))
        else $error("count moved outside frame");

    AST_CONV_BOUND: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        state_r == SASR_CONV |-> edge_cnt_r < EDGE_LAST)
        else $error("conversion past edge 17");

    AST_NO_REENTRY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_low && !cs_fall && state_r == SASR_ACQ |=> state_r == SASR_ACQ)
        else $error("second conversion in frame");

    AST_SAMPLE_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !cs_fall |=> $stable(sample_r))
        else $error("sample changed mid frame");

    AST_CONV_FLAG: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !cs_low |=> !conv_r)
        else $error("converting while select high");

    AST_CONV_OUT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_frame_open |=> conv_r)
        else $error("converting flag not raised");

    AST_EDGE8: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_fall && sck_fall |=> edge_cnt_r == CNT_W'(1) && conv_r)
        else $error("joint fall not taken as edge one");

    AST_LAST_EDGE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_last_edge |=> bits_sent_r == CNT_W'(DATA_W) && !conv_r)
        else $error("frame end not reached at edge 18");

    //------------------------------------------------------------
    // data output checks
    //------------------------------------------------------------
    AST_FIRST_QUIET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_frame_open |=> !oe_r)
        else $error("output driven on first edge");

    AST_OE_AFTER_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        oe_r |-> edge_cnt_r >= EDGE_ZERO)
        else $error("output driven before edge two");

    AST_OE_STAYS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_low && !cs_fall && oe_r |=> oe_r)
        else $error("output released inside frame");

    AST_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_low && step && edge_cnt_nxt == EDGE_ZERO |=> shift_r == sample_r)
        else $error("result not loaded at edge two");

    AST_MSB_THIRD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_low && step && edge_cnt_nxt == EDGE_MSB |=> oe_r && dout_r == sample_r[DATA_W-1])
        else $error("msb not on edge three");

    AST_BIT_ORDER: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_result_bit |=> dout_r == sample_r[DATA_W - 1 - $past(bits_sent_r)])
        else $error("result bit out of order");

    AST_SHIFT_LEFT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_result_bit |=> shift_r == {$past(shift_r[DATA_W-2:0]), 1'b0})
        else $error("shift register not advanced");

    AST_BITS_MAX: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        bits_sent_r <= CNT_W'(DATA_W))
        else $error("too many result bits");

    AST_BITS_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_frame_open |=> bits_sent_r == '0)
        else $error("bit count not cleared");

    AST_DOUT_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        cs_low && !step |=> dout_r == $past(dout_r))
        else $error("data moved without clock fall");

    AST_RISE_RELEASE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_rise_seen |=> !dout_r && !conv_r)
        else $error("select rise left output active");
endmodule // sasr_readout

/* File: sasr_pkg.sv */
// package for the serial converter readout block
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
package sasr_pkg;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned CNT_W        = 5;
    localparam logic [4:0]  EDGE_ZERO    = 5'h02;
    localparam logic [4:0]  EDGE_MSB     = 5'h03;
    localparam logic [4:0]  EDGE_LAST    = 5'h12;
    localparam logic [15:0] POS_FULL     = 16'h7fff;
    localparam logic [15:0] NEG_FULL     = 16'h8000;

    typedef enum logic [1:0] {
        SASR_ACQ  = 2'b00,
        SASR_CONV = 2'b01
    } sasr_state_e;

    typedef struct packed {
        logic dout;
        logic dout_oe;
    } sasr_pin_s;
endpackage

/* File: sasr_host.sv */
// host controller model driving select and serial clock
`timescale 1ns/1ps
module sasr_host (
    input  wire logic i_clk,
    input  wire logic i_pin,
    input  wire logic i_conv,
    output logic      o_cs_n,
    output logic      o_sclk
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
    end
    // mode 0 clock low, 1 clock high, 2 both fall together
    task automatic frame(input int mode, input int nf, output logic [17:0] w,
                         output logic c);
        o_sclk = (mode != 0);
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b0;
        if (mode == 2) o_sclk = 1'b0;
        for (int k = 1; k <= nf; k++) begin
            if (k > 1 || mode == 1) begin
                repeat (8) @(negedge i_clk);
                o_sclk = 1'b0;
            end
            repeat (8) @(negedge i_clk);
            o_sclk = 1'b1;
            if (k <= 18) w = {w[16:0], i_pin};
            c = i_conv;
        end
        repeat (8) @(negedge i_clk);
        o_cs_n = 1'b1;
        repeat (8) @(negedge i_clk);
        o_sclk = 1'b0;
        repeat (40) @(negedge i_clk);
    endtask
endmodule // sasr_host

/* File: test_sasr_readout.sv */
// self-checking bench for the serial converter readout block
`timescale 1ns/1ps
module test_sasr_readout;
    import sasr_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              cs_n, sclk, pin, conv, oe, dout, c;
    logic [DATA_W-1:0] code = '0;
    logic [DATA_W-1:0] smp;
    logic [17:0]       w;
    int                err_count = 0;
    int                check_count = 0;
    always #5 clk = ~clk;
    assign pin = oe ? dout : 1'bz;
    sasr_readout dut (.i_sys_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_ain_code(code), .o_dout(dout), .o_dout_oe(oe), .o_converting(conv),
        .o_sample(smp));
    sasr_host host (.i_clk(clk), .i_pin(pin), .i_conv(conv), .o_cs_n(cs_n),
        .o_sclk(sclk));
    task automatic chk(input string n, input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // full frame, input changes mid-frame to prove the sample is held
    task automatic t_full(input string n, input int mode, input logic [15:0] v);
        code = v;
        fork
            host.frame(mode, 21, w, c);
            begin
                repeat (30) @(negedge clk);
                code = ~v;
            end
        join
        chk("word", w, {1'bz, 1'b0, v});
        chk("sample", smp, v);
        chk("conv end", c, 1'b0);
        chk("idle", {oe, conv}, 2'b00);
        $display("test %s done", n);
    endtask
    // short frame aborted by select rise, then a clean frame
    task automatic t_abort;
        code = 16'h5a3c;
        host.frame(0, 8, w, c);
        chk("abort conv", c, 1'b1);
        chk("abort idle", {oe, conv}, 2'b00);
        $display("test abort done");
        t_full("after abort", 0, 16'h0f81);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("reset", {oe, conv, smp}, 18'h0);
        t_full("clock low", 0, POS_FULL);
        t_full("clock high", 1, NEG_FULL);
        t_full("together", 2, 16'hc3a5);
        t_abort;
        test_done;
    end
    initial begin
        #100us;
        err_count++;
        test_done;
    end
endmodule // test_sasr_readout
